// File: pkg/mshb_map.vh
// Address windows, reset values and bus constants for the master-slave halt bridge.
`ifndef MSHB_MAP_VH
`define MSHB_MAP_VH

// Slave halt window is 2000h..2FFFh: upper nibble of the 16-bit address.
`define MSHB_WIN_NIBBLE     4'h2
`define MSHB_WIN_HI         15
`define MSHB_WIN_LO         12
// Register byte addresses on the APB.
`define MSHB_REG_LATCH      12'h000
`define MSHB_REG_LIVE       12'h004
`define MSHB_REG_CTRL       12'h008
`define MSHB_REG_STATUS     12'h00C
// Control register bit positions.
`define MSHB_CTRL_HALT_N    0
`define MSHB_CTRL_OVERRIDE  1
`define MSHB_CTRL_STEP      2
`define MSHB_CTRL_RST_A_N   3
`define MSHB_CTRL_RST_B_N   4
`define MSHB_CTRL_LINK_A    5
`define MSHB_CTRL_LINK_B    6
`define MSHB_CTRL_SEL_B     7
`define MSHB_CTRL_W         8
// Control reset value: halt request high (inactive), both slaves in reset.
`define MSHB_CTRL_RESET     8'h01
`define MSHB_BYTE_RESET     8'h00
// Synchroniser reset value: each pin starts at its idle level, so no false edge follows reset.
// Set bits: read direction (12), strobe (11), proto wait (2), proto resets (1, 0).
`define MSHB_SYNC_RESET     29'h0000_1807

`endif

// File: core/mshb_sync.v
// Two-flop synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/1ps

module mshb_sync #(
    parameter         W   = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input  wire         clock,
    input  wire         nrst,
    // Data
    input  wire [W-1:0] d_in,
    output wire [W-1:0] d_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // The first stage is read only by the second stage.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST;
            sync_q <= RST;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign d_out = sync_q;

endmodule

// File: core/mshb_bridge.v
// Master-slave halt bridge: latching transceiver, wait generator and slave resets.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "mshb_map.vh"

// How it works
// RULE1 - Master writes captured in held latch
// RULE2 - Master reads return live slave bus
// RULE3 - Latch drives slave reads in window/override
// RULE4 - Slave writes never update the latches
// RULE5 - Window accesses raise wait automatically
// RULE6 - Master writes byte, then pulses step
// RULE7 - After release, halt again next strobe
// RULE8 - Override only used outside window
// RULE9 - Override disables off-chip memory selects
// RULE10 - Master branches into window, drops override
// RULE11 - Halt request stalls at next strobe
// RULE12 - Only step rising edge clears wait; the code also clears it while the selected slave is in reset
// RULE13 - Each slave reset follows its line
// RULE14 - Link enable joins slave and proto reset
// RULE15 - Slave strobes low on off-chip cycles
// RULE16 - Wait stays latched until master releases
// RULE17 - Stop when halt low or window address
// RULE18 - Slave wait is AND with proto wait
// RULE19 - Slave-side drive only on qualifying reads
// RULE20 - Wait inactive while slave in reset
module mshb_bridge (
    // Clock and reset
    input  wire        clock,
    input  wire        nrst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Slave external bus (asynchronous pins)
    input  wire [15:0] slave_addr,
    input  wire        slave_rnw,
    input  wire        external_strobe,
    input  wire [7:0]  slave_data_in,
    output reg  [7:0]  slave_data_out,
    output reg         slave_data_oe_n,
    output reg         offchip_enable,
    // Wait pins
    input  wire        proto_wait_in,
    output reg         slave_wait_n,
    output reg         wait_request_out,
    // Resets
    output reg         slave_a_reset_n,
    output reg         slave_b_reset_n,
    output reg         slave_a_reset_link_en,
    output reg         slave_b_reset_link_en,
    input  wire        proto_reset_a_in,
    input  wire        proto_reset_b_in,
    output reg         proto_reset_a_out,
    output reg         proto_reset_a_oe_n,
    output reg         proto_reset_b_out,
    output reg         proto_reset_b_oe_n
);

    localparam SW = 29;

    // Registers.
    reg [7:0]             latch_q;
    reg [`MSHB_CTRL_W-1:0] ctrl_q;
    reg                   step_prev_q;
    reg                   strobe_prev_q;
    reg                   wait_q;
    reg                   cycle_halted_q;
    reg [7:0]             live_q;

    // Synchronised pins.
    wire [SW-1:0] sync_out;
    wire [15:0]   s_addr;
    wire          s_rnw;
    wire          s_strobe;
    wire [7:0]    s_data;
    wire          s_pwait;
    wire          s_prst_a;
    wire          s_prst_b;

    mshb_sync #(
        .W   (SW),
        .RST (`MSHB_SYNC_RESET)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d_in  ({slave_addr, slave_rnw, external_strobe, slave_data_in,
                 proto_wait_in, proto_reset_a_in, proto_reset_b_in}),
        .d_out (sync_out)
    );

    assign s_addr   = sync_out[28:13];
    assign s_rnw    = sync_out[12];
    assign s_strobe = sync_out[11];
    assign s_data   = sync_out[10:3];
    assign s_pwait  = sync_out[2];
    assign s_prst_a = sync_out[1];
    assign s_prst_b = sync_out[0];

    // Control fields.
    wire halt_request = ctrl_q[`MSHB_CTRL_HALT_N];
    wire bus_override = ctrl_q[`MSHB_CTRL_OVERRIDE];
    wire step_release = ctrl_q[`MSHB_CTRL_STEP];
    wire sel_b        = ctrl_q[`MSHB_CTRL_SEL_B];

    // Decoded conditions.
    wire in_window   = (s_addr[`MSHB_WIN_HI:`MSHB_WIN_LO] == `MSHB_WIN_NIBBLE);
    wire stop_cond   = !halt_request || in_window; // RULE17
    wire strobe_fall = strobe_prev_q && !s_strobe;
    wire step_rise   = step_release && !step_prev_q;
    wire sel_in_rst  = sel_b ? !ctrl_q[`MSHB_CTRL_RST_B_N] : !ctrl_q[`MSHB_CTRL_RST_A_N];
    wire drive_now   = !s_strobe && s_rnw && (in_window || bus_override);

    // APB access phase.
    wire apb_acc = psel && penable;
    wire apb_wr  = apb_acc && pwrite;

    // APB slave: zero-wait answer, error on unmapped offset.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == `MSHB_REG_LATCH) begin
                    prdata <= {24'h00_0000, latch_q};
                end else if (paddr == `MSHB_REG_LIVE) begin
                    prdata <= {24'h00_0000, s_data}; // RULE2
                end else if (paddr == `MSHB_REG_CTRL) begin
                    prdata <= {24'h00_0000, ctrl_q};
                end else if (paddr == `MSHB_REG_STATUS) begin
                    prdata <= {29'h0000_0000, s_pwait, cycle_halted_q, wait_q};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Write registers: only the master writes the latch, never the slave.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latch_q <= `MSHB_BYTE_RESET;
            ctrl_q  <= `MSHB_CTRL_RESET;
        end else if (apb_wr && pready) begin
            if (paddr == `MSHB_REG_LATCH) begin
                latch_q <= pwdata[7:0]; // RULE1 RULE4
            end else if (paddr == `MSHB_REG_CTRL) begin
                ctrl_q <= pwdata[`MSHB_CTRL_W-1:0];
            end
        end
    end

    // Edge history for strobe and step.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            step_prev_q   <= 1'b0;
            strobe_prev_q <= 1'b1;
            live_q        <= `MSHB_BYTE_RESET;
        end else begin
            step_prev_q   <= step_release;
            strobe_prev_q <= s_strobe;
            live_q        <= s_data;
        end
    end

    // Wait generator: set on strobe fall with stop, clear on step rise or while the selected slave is in reset.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q         <= 1'b0;
            cycle_halted_q <= 1'b0;
        end else if (sel_in_rst) begin
            wait_q         <= 1'b0; // RULE20
            cycle_halted_q <= 1'b0;
        end else if (strobe_fall && stop_cond) begin
            wait_q         <= 1'b1; // RULE5 RULE7 RULE11
            cycle_halted_q <= 1'b1;
        end else if (step_rise) begin
            wait_q         <= 1'b0; // RULE12 RULE16
        end else if (s_strobe) begin
            cycle_halted_q <= 1'b0;
        end
    end

    // Wait pins: generator output, ANDed with proto wait on slave_wait_n only.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_request_out <= 1'b1;
            slave_wait_n     <= 1'b1;
        end else begin
            wait_request_out <= !wait_q;
            slave_wait_n     <= !wait_q && s_pwait; // RULE18
        end
    end

    // Transceiver slave side and off-chip select gating.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slave_data_out  <= `MSHB_BYTE_RESET;
            slave_data_oe_n <= 1'b1;
            offchip_enable  <= 1'b0;
        end else begin
            slave_data_out  <= latch_q; // RULE3
            slave_data_oe_n <= !drive_now; // RULE19
            offchip_enable  <= !bus_override && !in_window; // RULE9
        end
    end

    // Slave resets and reset link switches.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slave_a_reset_n       <= 1'b0;
            slave_b_reset_n       <= 1'b0;
            slave_a_reset_link_en <= 1'b0;
            slave_b_reset_link_en <= 1'b0;
            proto_reset_a_out     <= 1'b0;
            proto_reset_a_oe_n    <= 1'b1;
            proto_reset_b_out     <= 1'b0;
            proto_reset_b_oe_n    <= 1'b1;
        end else begin
            // Closed link: reset pin pulled by either side.
            slave_a_reset_n       <= ctrl_q[`MSHB_CTRL_RST_A_N] &&
                                     (!ctrl_q[`MSHB_CTRL_LINK_A] || s_prst_a); // RULE13 RULE14
            slave_b_reset_n       <= ctrl_q[`MSHB_CTRL_RST_B_N] &&
                                     (!ctrl_q[`MSHB_CTRL_LINK_B] || s_prst_b); // RULE13 RULE14
            slave_a_reset_link_en <= ctrl_q[`MSHB_CTRL_LINK_A];
            slave_b_reset_link_en <= ctrl_q[`MSHB_CTRL_LINK_B];
            proto_reset_a_out     <= 1'b0;
            proto_reset_a_oe_n    <= !(ctrl_q[`MSHB_CTRL_LINK_A] &&
                                       !ctrl_q[`MSHB_CTRL_RST_A_N]); // RULE14
            proto_reset_b_out     <= 1'b0;
            proto_reset_b_oe_n    <= !(ctrl_q[`MSHB_CTRL_LINK_B] &&
                                       !ctrl_q[`MSHB_CTRL_RST_B_N]); // RULE14
        end
    end

endmodule

// File: verification/mshb_slave_model.sv
// Behavioural slave bus that runs strobe cycles and stalls while wait is low.
`timescale 1ns/1ps
module mshb_slave_model (
    // Clock
    input  wire         clock,
    // Slave bus
    output logic [15:0] slave_addr = 16'h0000,
    output logic        slave_rnw = 1'h1,
    output logic        external_strobe = 1'h1,
    output wire  [7:0]  slave_data_in,
    input  wire  [7:0]  slave_data_out,
    input  wire         slave_data_oe_n,
    input  wire         slave_wait_n
);
    logic [7:0] last_q = 8'h00;
    logic [7:0] wd_q = 8'h00;
    logic       drv_q = 1'h0;
    // A bus nobody drives shows the inverse of its last level, never a stale copy.
    assign slave_data_in = !slave_data_oe_n ? slave_data_out : drv_q ? wd_q : ~last_q;
    always @(posedge clock) begin
        last_q <= slave_data_in;
    end
    // One strobe cycle of six clocks at least, stretched while wait is low.
    task automatic cycle(input logic [15:0] a, input logic r, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        int i;
        slave_addr <= a;
        slave_rnw <= r;
        external_strobe <= 1'h0;
        drv_q <= !r;
        wd_q <= d;
        repeat (6) @(posedge clock);
        for (i = 0; i < 60 && slave_wait_n !== 1'h1; i++) @(posedge clock);
        q = slave_data_in;
        ok = i < 60;
        external_strobe <= 1'h1;
        drv_q <= 1'h0;
        @(posedge clock);
    endtask
endmodule

// File: verification/mshb_checker.sv
// Pin assertions for the master-slave halt bridge.
`timescale 1ns/1ps
module mshb_checker (
    // Clock, reset and APB
    input wire        clock, nrst, psel, penable, pready, pslverr,
    // Slave bus
    input wire [15:0] slave_addr,
    input wire        slave_rnw, external_strobe, slave_data_oe_n, offchip_enable,
    // Waits and resets
    input wire        proto_wait_in, slave_wait_n, wait_request_out, slave_a_reset_n,
    input wire        slave_b_reset_n, slave_a_reset_link_en, proto_reset_a_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Each check ties an output to its cause with the documented delay.
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no pready in access");
    a_win_halt: assert property ($fell(external_strobe) && slave_addr[15:12] == 4'h2
        && slave_a_reset_n && slave_b_reset_n |-> ##[2:5] !wait_request_out)
        else $error("window not halted");
    a_wait_pin: assert property ($fell(wait_request_out) |-> ##[0:3] !slave_wait_n)
        else $error("wait not on pin");
    a_proto_wait: assert property (!proto_wait_in [*5] |-> !slave_wait_n)
        else $error("proto wait lost");
    a_reset_gate: assert property ((!slave_a_reset_n && !slave_b_reset_n) [*2] |-> wait_request_out)
        else $error("wait in reset");
    a_write_float: assert property (!slave_rnw [*4] |-> slave_data_oe_n)
        else $error("drive on write");
    a_drive_alone: assert property (!slave_data_oe_n |-> !offchip_enable)
        else $error("offchip on while driving");
    a_link_open: assert property (!slave_a_reset_link_en |-> proto_reset_a_oe_n)
        else $error("proto reset driven");
    // Main scenarios.
    cover property (!wait_request_out);
    cover property (!slave_data_oe_n && !offchip_enable);
    cover property (pslverr);
endmodule
bind mshb_bridge mshb_checker chk (.clock, .nrst, .psel, .penable, .pready, .pslverr,
    .slave_addr, .slave_rnw, .external_strobe, .slave_data_oe_n, .offchip_enable,
    .proto_wait_in, .slave_wait_n, .wait_request_out, .slave_a_reset_n, .slave_b_reset_n,
    .slave_a_reset_link_en, .proto_reset_a_oe_n);

// File: verification/mshb_bridge_bench.sv
// Random and corner tests for the master-slave halt bridge.
`timescale 1ns/1ps
`include "mshb_map.vh"
module mshb_bridge_bench;
    logic        clock = '0, nrst = '0, psel = '0, penable = '0, pwrite = '0, proto_wait_in = '1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, cv, k;
    logic [15:0] slave_addr;
    logic [7:0]  slave_data_in, slave_data_out, lb, pr, d;
    logic        pready, pslverr, slave_rnw, external_strobe, slave_data_oe_n, offchip_enable;
    logic        slave_wait_n, wait_request_out, slave_a_reset_n, slave_b_reset_n, ok, er;
    logic        slave_a_reset_link_en, slave_b_reset_link_en, proto_reset_a_oe_n, proto_reset_b_oe_n;
    int          failures = 0, n_checks = 0;
    mshb_slave_model p (.clock, .slave_addr, .slave_rnw, .external_strobe, .slave_data_in,
        .slave_data_out, .slave_data_oe_n, .slave_wait_n);
    // Proto reset pins have pull-ups, so their level follows the drive enable.
    mshb_bridge dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .slave_addr, .slave_rnw, .external_strobe, .slave_data_in, .slave_data_out,
        .slave_data_oe_n, .offchip_enable, .proto_wait_in, .slave_wait_n, .wait_request_out,
        .slave_a_reset_n, .slave_b_reset_n, .slave_a_reset_link_en, .slave_b_reset_link_en,
        .proto_reset_a_in(proto_reset_a_oe_n), .proto_reset_b_in(proto_reset_b_oe_n),
        .proto_reset_a_out(), .proto_reset_a_oe_n, .proto_reset_b_out(), .proto_reset_b_oe_n);
    initial forever #2.5 clock = ~clock;
    // Counts and reports one comparison.
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int i;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        for (i = 0; i < 9; i++) begin
            @(posedge clock);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        er = pslverr;
        if (i == 9) begin
            failures++;
            stop_test;
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    // Step rises from low and ends at the level held in cv.
    task step;
        apb(1'h1, `MSHB_REG_CTRL, cv & ~32'h4);
        apb(1'h1, `MSHB_REG_CTRL, cv | 32'h4);
        apb(1'h1, `MSHB_REG_CTRL, cv);
    endtask
    // A slave cycle; when a halt is expected the live bus is read, then stepped.
    task cyc(input logic [15:0] a, input logic r, input logic h);
        int i;
        d = $urandom;
        fork
            p.cycle(a, r, d, pr, ok);
            if (h) begin
                for (i = 0; i < 20 && slave_wait_n !== 1'h0; i++) @(posedge clock);
                chk("halt", 32'h0, slave_wait_n);
                apb(1'h0, `MSHB_REG_LIVE, 32'h0);
                chk("live", {24'h0, r ? lb : d}, rd);
                apb(1'h0, `MSHB_REG_STATUS, 32'h0);
                chk("status", 32'h7, rd);
                step;
            end
        join
        chk("done", 32'h1, ok);
    endtask
    initial begin
        k = $urandom(93);
        repeat (16) @(posedge clock);
        nrst <= 1'h1;
        @(posedge clock);
        chk("rst_a", 32'h0, slave_a_reset_n);
        apb(1'h0, `MSHB_REG_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        cv = 32'h39;
        apb(1'h1, `MSHB_REG_CTRL, cv);
        // Pins change at the edge that ends the write; look once they have settled.
        @(negedge clock);
        chk("pins", 32'h6, {slave_a_reset_n, slave_b_reset_n, slave_b_reset_link_en});
        chk("link_a", 32'h1, slave_a_reset_link_en);
        @(posedge clock);
        apb(1'h0, 12'h010, 32'h0);
        chk("slverr", 32'h1, er);
        $display("reset test done");
        repeat (6) begin
            k = $urandom;
            lb = k[7:0];
            apb(1'h1, `MSHB_REG_LATCH, k);
            apb(1'h0, `MSHB_REG_LATCH, 32'h0);
            chk("latch", {24'h0, lb}, rd);
            cyc({4'h2, k[31:20]}, 1'h1, 1'h1);
            chk("slave_rd", {24'h0, lb}, pr);
            cyc({4'h2, k[19:8]}, 1'h0, 1'h1);
            apb(1'h0, `MSHB_REG_LATCH, 32'h0);
            chk("kept", {24'h0, lb}, rd);
        end
        $display("window test done");
        cv = 32'h3B;
        apb(1'h1, `MSHB_REG_CTRL, cv);
        cyc(16'h4000, 1'h1, 1'h0);
        chk("ovr_rd", {24'h0, lb}, pr);
        chk("offchip", 32'h0, offchip_enable);
        cyc(16'h2800, 1'h1, 1'h1);
        cv = 32'h38;
        apb(1'h1, `MSHB_REG_CTRL, cv);
        cyc(16'h4000, 1'h0, 1'h1);
        cyc(16'h4001, 1'h0, 1'h1);
        cv = 32'h3D;
        apb(1'h1, `MSHB_REG_CTRL, cv);
        cyc(16'h2FFF, 1'h1, 1'h1);
        $display("override and halt test done");
        proto_wait_in <= 1'h0;
        repeat (5) @(posedge clock);
        chk("proto_wait", 32'h0, slave_wait_n);
        proto_wait_in <= 1'h1;
        repeat (5) @(posedge clock);
        chk("wait_free", 32'h1, slave_wait_n);
        cv = 32'h31;
        apb(1'h1, `MSHB_REG_CTRL, cv);
        @(negedge clock);
        chk("rst_a_low", 32'h0, slave_a_reset_n);
        @(posedge clock);
        cyc(16'h2000, 1'h1, 1'h0);
        $display("wait and reset test done");
        stop_test;
    end
endmodule
